//--- hrs_defines.vh
/*
  Constants of the hardware reset sequencer: machine-cycle timing, register
  offsets, field positions and reset values.
  Assumes a single oscillator clock at 200 MHz and a 32-bit register bus.
*/
`ifndef HRS_DEFINES_VH
`define HRS_DEFINES_VH

// ****************************************
// machine cycle timing
// ****************************************
`define HRS_CLK_MHZ        200
`define HRS_PHASE_LAST     4'hB
`define HRS_PRE_S5P1       4'h7
`define HRS_S5P2           4'h9
`define HRS_MIN_RESET_OSC  24
`define HRS_PROC_CLKS      5'h18
`define HRS_WD_LIMIT       16'hFFFF

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define HRS_OFS_STATUS     8'h00
`define HRS_OFS_CONTROL    8'h04
`define HRS_OFS_PORT_LO    8'h08
`define HRS_OFS_PORT_HI    8'h0C
`define HRS_OFS_STACK      8'h10
`define HRS_OFS_DATA_POINTER_PAIR       8'h14
`define HRS_OFS_IADDR      8'h18
`define HRS_OFS_WDOG       8'h1C
`define HRS_OFS_RAM        8'h40
`define HRS_RAM_WORDS      16

// ****************************************
// field positions
// ****************************************
`define HRS_ST_IN_RESET    0
`define HRS_ST_RUNNING     1
`define HRS_ST_PWR_DOWN    2
`define HRS_ST_CAUSE_EXT   3
`define HRS_ST_CAUSE_WDT   4
`define HRS_CT_PWR_DOWN    0
`define HRS_CT_WD_ENABLE   1

// ****************************************
// reset values
// ****************************************
`define HRS_RST_STACK      8'h07
`define HRS_RST_DATA_POINTER_PAIR       16'h0000
`define HRS_RST_IADDR      16'h0000
`define HRS_RST_WDOG       16'h0000
`define HRS_RST_CTRL       8'h00
`define HRS_RST_PORT       8'hFF

`endif

//--- hrs_cycle_timer.v
/*
  Machine-cycle phase counter: twelve oscillator periods per machine cycle.
  Assumes clk is the running oscillator clock.
*/
`timescale 1ns/1ps
`include "hrs_defines.vh"

module hrs_cycle_timer (
  // clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // phase position
  output reg  [3:0] phase_q,
  output wire       at_pre_s5p1,
  output wire       at_s5p2,
  output wire       at_last
);

  // ****************************************
  // phase count
  // ****************************************
  reg [3:0] phase_d;

  always @* begin
    phase_d = phase_q + 4'h1;
    if (phase_q == `HRS_PHASE_LAST) begin
      phase_d = 4'h0;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign at_pre_s5p1 = (phase_q == `HRS_PRE_S5P1);
  assign at_s5p2     = (phase_q == `HRS_S5P2);
  assign at_last     = (phase_q == `HRS_PHASE_LAST);

endmodule

//--- hrs_port_bank.v
/*
  Six 8-bit port latches with their output drivers.
  Assumes the caller asserts load_ones for the whole internal reset.
*/
`timescale 1ns/1ps
`include "hrs_defines.vh"

module hrs_port_bank (
  // clock and reset
  input  wire        clk,
  input  wire        load_ones,
  // latch writes
  input  wire [5:0]  wr_en,
  input  wire [47:0] wr_data,
  // latch and pin side
  output wire [47:0] latch_q,
  output wire [47:0] pin_o,
  output wire [47:0] pin_oe
);

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gen_port
      reg [7:0] lat_q;
      always @(posedge clk) begin
        if (load_ones) begin
          lat_q <= `HRS_RST_PORT;
        end else if (wr_en[g]) begin
          lat_q <= wr_data[g*8 +: 8];
        end
      end
      assign latch_q[g*8 +: 8] = lat_q;
      if (g == 0) begin : gen_open_drain
        // port 0 only sinks; a one leaves the pin floating
        assign pin_o[7:0]  = 8'h00;
        assign pin_oe[7:0] = ~lat_q;
      end else begin : gen_push
        assign pin_o[g*8 +: 8]  = lat_q;
        assign pin_oe[g*8 +: 8] = 8'hFF;
      end
    end
  endgenerate

endmodule

//--- hrs_reset_sequencer.v
/*
  Hardware reset sequencer: samples the reset pin, merges the watchdog
  request, runs the internal reset (watchdog: two machine cycles; pin: until sampled high), restarts fetching and serves
  a small Avalon-MM register file.
  Assumes reset_pin_b is synchronous to clk and clk is the oscillator.
*/
`timescale 1ns/1ps
`include "hrs_defines.vh"

module hrs_reset_sequencer #(
  parameter [15:0] WD_LIMIT = `HRS_WD_LIMIT
) (
  // clock and power-on reset
  input  wire        clk,
  input  wire        rst_b,
  // reset pin and fetch select pin
  input  wire        reset_pin_b,
  input  wire        external_fetch_select,
  // avalon-mm slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // address latch strobe pin
  output wire        ale_o,
  output wire        ale_oe,
  // program fetch strobe pin, active low
  output wire        program_fetch_strobe_b_o,
  output wire        program_fetch_strobe_oe,
  // fetch address
  output wire [15:0] fetch_address,
  output wire        fetch_address_oe,
  // port pins
  output wire [47:0] port_o,
  output wire [47:0] port_oe,
  // core status
  output wire        core_reset,
  output wire        core_halt
);

  // ****************************************
  // machine cycle timing
  // ****************************************
  wire [3:0] phase_q;
  wire       at_pre_s5p1;
  wire       at_s5p2;
  wire       at_last;

  hrs_cycle_timer u_timer (
    .clk         (clk),
    .rst_b       (rst_b),
    .phase_q     (phase_q),
    .at_pre_s5p1 (at_pre_s5p1),
    .at_s5p2     (at_s5p2),
    .at_last     (at_last)
  );

  // ****************************************
  // reset pin sampling
  // ****************************************
  // everything below is clocked; with no oscillator nothing can happen
  reg  [1:0] low_cnt_q;
  reg        ext_active_q;
  reg  [4:0] proc_cnt_q;
  reg        core_reset_q;
  reg        run_q;
  reg        wdt_fire_q;
  wire       ext_start;
  wire       any_start;
  reg  [4:0] proc_cnt_d;
  reg        ext_active_d;

  // second consecutive low sample starts the internal reset
  assign ext_start = at_s5p2 & ~reset_pin_b & (low_cnt_q != 2'h0);
  assign any_start = ext_start | wdt_fire_q;

  always @(posedge clk) begin
    if (!rst_b) begin
      low_cnt_q <= 2'h0;
    end else if (at_s5p2) begin
      if (reset_pin_b) begin
        low_cnt_q <= 2'h0;
      end else if (low_cnt_q != 2'h2) begin
        low_cnt_q <= low_cnt_q + 2'h1;
      end
    end
  end

  always @* begin
    ext_active_d = ext_active_q;
    if (ext_start) begin
      ext_active_d = 1'b1;
    end else if (at_s5p2 & reset_pin_b) begin
      ext_active_d = 1'b0;
    end
    proc_cnt_d = proc_cnt_q;
    // only the watchdog needs the counter: a pin reset began its procedure at the
    // first low sample and ends at a high sample at least two machine cycles later;
    // extending it past that sample would push the first strobe beyond two cycles
    if (wdt_fire_q) begin
      proc_cnt_d = `HRS_PROC_CLKS;
    end else if (proc_cnt_q != 5'h00) begin
      proc_cnt_d = proc_cnt_q - 5'h01;
    end
  end

  // ****************************************
  // internal reset and restart
  // ****************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      ext_active_q <= 1'b0;
      proc_cnt_q   <= 5'h00;
      core_reset_q <= 1'b1;
      run_q        <= 1'b0;
    end else begin
      ext_active_q <= ext_active_d;
      proc_cnt_q   <= proc_cnt_d;
      // watchdog: two machine cycles; pin: until the pin is sampled high
      core_reset_q <= any_start | ext_active_d | (proc_cnt_d != 5'h00);
      if (core_reset_q) begin
        run_q <= 1'b0;
      end else if (at_pre_s5p1) begin
        run_q <= 1'b1;
      end
    end
  end

  assign core_reset = core_reset_q;

  // ****************************************
  // power-down and control
  // ****************************************
  reg  [7:0]  ctrl_q;
  reg  [7:0]  stack_q;
  reg  [15:0] data_pointer_pair_q;
  reg  [15:0] iaddr_q;
  reg  [15:0] wdog_q;
  reg         cause_ext_q;
  reg         cause_wdt_q;
  wire        pwr_down;
  wire        run_eff;
  wire        ext_fetch;
  wire        strobe_win;
  wire        ale_win;

  assign pwr_down  = ctrl_q[`HRS_CT_PWR_DOWN];
  assign core_halt = pwr_down;
  assign run_eff   = run_q & ~pwr_down;
  assign ext_fetch = external_fetch_select | (iaddr_q[15:13] != 3'h0);

  // ****************************************
  // strobes and fetch address
  // ****************************************
  // ale high in S1P2..S2P1 and S4P2..S5P1; the first after release is S5P1 only
  assign ale_win = (phase_q == 4'h1) | (phase_q == 4'h2) |
                   (phase_q == 4'h7) | (phase_q == 4'h8);
  assign strobe_win = ((phase_q >= 4'h3) & (phase_q <= 4'h5)) | (phase_q >= 4'h9);

  assign ale_o   = run_eff & ale_win;
  assign ale_oe  = ~core_reset_q;
  assign program_fetch_strobe_b_o = ~(run_eff & ext_fetch & strobe_win);
  assign program_fetch_strobe_oe  = ~core_reset_q;
  assign fetch_address    = iaddr_q;
  assign fetch_address_oe = run_eff & ext_fetch;

  // ****************************************
  // avalon-mm handshake
  // ****************************************
  // one wait cycle, so read data comes from a flop
  reg         ack_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  wire        req;
  wire        wr_take;
  wire [3:0]  ram_idx;
  wire        ram_hit;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign wr_take         = avs_write & ack_q & avs_byteenable[0];
  assign ram_idx         = avs_address[5:2];
  assign ram_hit         = (avs_address[7:6] == 2'h1) & (avs_address[1:0] == 2'h0);

  // ****************************************
  // internal ram, never reset
  // ****************************************
  reg [7:0] ram_q [0:`HRS_RAM_WORDS-1];

  always @(posedge clk) begin
    if (wr_take & ram_hit) begin
      ram_q[ram_idx] <= avs_writedata[7:0];
    end
  end

  // ****************************************
  // port latches
  // ****************************************
  wire [47:0] latch_q;
  wire [5:0]  port_wr;
  wire [47:0] port_wdata;
  wire        wr_lo;
  wire        wr_hi;

  assign wr_lo = avs_write & ack_q & (avs_address == `HRS_OFS_PORT_LO);
  assign wr_hi = avs_write & ack_q & (avs_address == `HRS_OFS_PORT_HI);
  assign port_wr = {{2{wr_hi}} & avs_byteenable[1:0], {4{wr_lo}} & avs_byteenable};
  assign port_wdata = {avs_writedata[15:0], avs_writedata};

  hrs_port_bank u_ports (
    .clk       (clk),
    .load_ones (~rst_b | core_reset_q),
    .wr_en     (port_wr),
    .wr_data   (port_wdata),
    .latch_q   (latch_q),
    .pin_o     (port_o),
    .pin_oe    (port_oe)
  );

  // ****************************************
  // read mux
  // ****************************************
  always @* begin
    rdata_d = 32'h0000_0000;
    if (ram_hit) begin
      rdata_d = {24'h00_0000, ram_q[ram_idx]};
    end else begin
      case (avs_address)
        `HRS_OFS_STATUS: begin
          rdata_d[`HRS_ST_IN_RESET]  = core_reset_q;
          rdata_d[`HRS_ST_RUNNING]   = run_q;
          rdata_d[`HRS_ST_PWR_DOWN]  = pwr_down;
          rdata_d[`HRS_ST_CAUSE_EXT] = cause_ext_q;
          rdata_d[`HRS_ST_CAUSE_WDT] = cause_wdt_q;
          rdata_d[11:8]              = phase_q;
        end
        `HRS_OFS_CONTROL: rdata_d = {24'h00_0000, ctrl_q};
        `HRS_OFS_PORT_LO: rdata_d = latch_q[31:0];
        `HRS_OFS_PORT_HI: rdata_d = {16'h0000, latch_q[47:32]};
        `HRS_OFS_STACK:   rdata_d = {24'h00_0000, stack_q};
        `HRS_OFS_DATA_POINTER_PAIR:    rdata_d = {16'h0000, data_pointer_pair_q};
        `HRS_OFS_IADDR:   rdata_d = {16'h0000, iaddr_q};
        `HRS_OFS_WDOG:    rdata_d = {16'h0000, wdog_q};
        default:          rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ****************************************
  // register defaults and updates
  // ****************************************
  wire wr_sel_ctrl;
  wire wr_sel_stack;
  wire wr_sel_data_pointer_pair;
  wire wr_sel_wdog;
  wire wr_sel_status;
  wire mc_end;
  wire wd_overflow;

  assign wr_sel_ctrl   = wr_take & (avs_address == `HRS_OFS_CONTROL);
  assign wr_sel_stack  = wr_take & (avs_address == `HRS_OFS_STACK);
  assign wr_sel_data_pointer_pair   = avs_write & ack_q & (avs_address == `HRS_OFS_DATA_POINTER_PAIR);
  assign wr_sel_wdog   = wr_take & (avs_address == `HRS_OFS_WDOG);
  assign wr_sel_status = wr_take & (avs_address == `HRS_OFS_STATUS);
  assign mc_end        = at_last;
  assign wd_overflow   = ctrl_q[`HRS_CT_WD_ENABLE] & mc_end & (wdog_q == WD_LIMIT);

  always @(posedge clk) begin
    if (!rst_b || core_reset_q) begin
      ctrl_q     <= `HRS_RST_CTRL;
      stack_q    <= `HRS_RST_STACK;
      data_pointer_pair_q     <= `HRS_RST_DATA_POINTER_PAIR;
      iaddr_q    <= `HRS_RST_IADDR;
      wdog_q     <= `HRS_RST_WDOG;
      wdt_fire_q <= 1'b0;
    end else begin
      wdt_fire_q <= wd_overflow;
      if (wr_sel_ctrl) begin
        ctrl_q <= avs_writedata[7:0];
      end
      if (wr_sel_stack) begin
        stack_q <= avs_writedata[7:0];
      end
      if (wr_sel_data_pointer_pair) begin
        if (avs_byteenable[0]) begin
          data_pointer_pair_q[7:0] <= avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          data_pointer_pair_q[15:8] <= avs_writedata[15:8];
        end
      end
      // a write to the watchdog register refreshes it
      if (wr_sel_wdog) begin
        wdog_q <= `HRS_RST_WDOG;
      end else if (ctrl_q[`HRS_CT_WD_ENABLE] & mc_end) begin
        wdog_q <= wdog_q + 16'h0001;
      end
      // fetch address advances at the end of each strobe window
      if (run_eff & ((phase_q == 4'h5) | at_last)) begin
        iaddr_q <= iaddr_q + 16'h0001;
      end
    end
  end

  // ****************************************
  // reset cause flags
  // ****************************************
  // survive the internal reset; write one to clear, a new cause wins
  always @(posedge clk) begin
    if (!rst_b) begin
      cause_ext_q <= 1'b0;
      cause_wdt_q <= 1'b0;
    end else begin
      if (ext_start) begin
        cause_ext_q <= 1'b1;
      end else if (wr_sel_status & avs_writedata[`HRS_ST_CAUSE_EXT]) begin
        cause_ext_q <= 1'b0;
      end
      if (wdt_fire_q) begin
        cause_wdt_q <= 1'b1;
      end else if (wr_sel_status & avs_writedata[`HRS_ST_CAUSE_WDT]) begin
        cause_wdt_q <= 1'b0;
      end
    end
  end

endmodule

//--- hrs_reset_supervisor.sv
/*
  Partner model: outside reset source driving the reset pin low on request.
  Assumes go is a one-cycle request and hold_clks stays steady with it.
*/
`timescale 1ns/1ps

module hrs_reset_supervisor (
  // clock
  input  wire       clk,
  // request
  input  wire       go,
  input  wire [7:0] hold_clks,
  // reset pin
  output reg        reset_pin_b
);
  // ****************************************
  // pin driver
  // ****************************************
  reg [7:0] cnt_q;

  initial begin
    reset_pin_b = 1'b1;
    cnt_q = 8'h00;
  end

  // strobe pins are never driven here, so no test mode is entered
  // pin low for hold_clks edges; the bench asks 24 or more unless testing a glitch
  always @(posedge clk) begin
    if (go && cnt_q == 8'h00) begin
      reset_pin_b <= 1'b0;
      cnt_q <= hold_clks;
    end else if (cnt_q > 8'h01) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (cnt_q == 8'h01) begin
      reset_pin_b <= 1'b1;
      cnt_q <= 8'h00;
    end
  end
endmodule

//--- hrs_reset_sequencer_props.sv
/*
  Checker of the reset sequencer's port behaviour.
  Assumes the phase count restarts at 0 with rst_b, as the design's does.
*/
`timescale 1ns/1ps

module hrs_reset_sequencer_props (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // watched ports
  input  wire        reset_pin_b,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire        avs_waitrequest,
  input  wire        ale_o,
  input  wire        ale_oe,
  input  wire        program_fetch_strobe_oe,
  input  wire [15:0] fetch_address,
  input  wire [47:0] port_o,
  input  wire [47:0] port_oe,
  input  wire        core_reset,
  input  wire        core_halt
);
  // ****************************************
  // helper logic
  // ****************************************
  reg [3:0] ph_q;
  reg       low_q;
  reg [5:0] cnt_q;
  reg       por_q;
  reg       pin_rst_q;

  // por_q masks the release after power-on, which skips the long procedure
  always @(posedge clk) begin
    if (!rst_b) begin
      ph_q <= 4'h0;
      low_q <= 1'b0;
      cnt_q <= 6'h00;
      por_q <= 1'b1;
      pin_rst_q <= 1'b0;
    end else begin
      ph_q <= (ph_q == 4'hB) ? 4'h0 : ph_q + 4'h1;
      if (ph_q == 4'h9) begin
        low_q <= !reset_pin_b;
      end
      cnt_q <= !core_reset ? 6'h00 : (cnt_q == 6'h3F) ? cnt_q : cnt_q + 6'h01;
      // frozen while in reset: tells a pin reset from a watchdog one
      if (!core_reset) begin
        por_q <= 1'b0;
        pin_rst_q <= !reset_pin_b;
      end
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_pins_input; core_reset |-> !ale_oe && !program_fetch_strobe_oe; endproperty
  a_pins_input: assert property (p_pins_input) else $error("strobe pin driven in reset");
  property p_second_low; ph_q == 4'h9 && !reset_pin_b && low_q |=> core_reset; endproperty
  a_second_low: assert property (p_second_low) else $error("no reset on second low");
  property p_sample_phase; $rose(core_reset) && !reset_pin_b |-> ph_q == 4'hA; endproperty
  a_sample_phase: assert property (p_sample_phase) else $error("reset off sample phase");
  // a pin reset's procedure starts one machine cycle before core_reset rises
  property p_length;
    $fell(core_reset) && !por_q |-> cnt_q >= (pin_rst_q ? 6'h0C : 6'h18);
  endproperty
  a_length: assert property (p_length) else $error("internal reset too short");
  property p_first_ale;
    $fell(core_reset) && !por_q |-> !ale_o [*6] ##[1:15] $fell(ale_o);
  endproperty
  a_first_ale: assert property (p_first_ale) else $error("first strobe misplaced");
  property p_start_addr;
    $fell(core_reset) && !por_q |-> (fetch_address == 16'h0000) [*8];
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("fetch not from zero");
  property p_ports;
    core_reset && $past(core_reset) |-> port_o[47:8] == 40'hFFFFFFFFFF
      && port_oe[47:8] == 40'hFFFFFFFFFF && port_o[7:0] == 8'h00 && port_oe[7:0] == 8'h00;
  endproperty
  a_ports: assert property (p_ports) else $error("port latches not ones");
  property p_halt_exit; core_reset |=> !core_halt; endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("power-down kept in reset");
  property p_bus_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus answer late");

  c_reset: cover property ($rose(core_reset));
  c_ale: cover property ($fell(core_reset) ##[1:30] $fell(ale_o));
  c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind hrs_reset_sequencer hrs_reset_sequencer_props u_props (
  .clk(clk), .rst_b(rst_b), .reset_pin_b(reset_pin_b), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .ale_o(ale_o),
  .ale_oe(ale_oe), .program_fetch_strobe_oe(program_fetch_strobe_oe),
  .fetch_address(fetch_address), .port_o(port_o), .port_oe(port_oe),
  .core_reset(core_reset), .core_halt(core_halt)
);

//--- test_mcu_hardware_reset_sequencer.sv
/*
  Testbench of the reset sequencer: defaults, glitch, pin resets, watchdog.
  Assumes the supervisor model drives the reset pin; 200 MHz clock.
*/
`timescale 1ns/1ps
`include "hrs_defines.vh"

module test_mcu_hardware_reset_sequencer;
  // ****************************************
  // signals
  // ****************************************
  reg         clk, rst_b, go, external_fetch_select, avs_read, avs_write, a;
  reg  [7:0]  hold_clks, avs_address, ra;
  reg  [31:0] avs_writedata, rd, ram_v;
  reg  [3:0]  avs_byteenable;
  wire [31:0] avs_readdata;
  wire [15:0] fetch_address;
  wire [47:0] port_o, port_oe;
  wire        avs_waitrequest, reset_pin_b, ale_o, ale_oe, core_reset, core_halt;
  wire        program_fetch_strobe_b_o, program_fetch_strobe_oe, fetch_address_oe;
  integer     err_total, total_checks, n, i, k, t;
  localparam [55:0] OFS = {8'h30, `HRS_OFS_WDOG, `HRS_OFS_CONTROL, `HRS_OFS_PORT_HI,
                           `HRS_OFS_PORT_LO, `HRS_OFS_DATA_POINTER_PAIR, `HRS_OFS_STACK};

  hrs_reset_supervisor sup_u (.clk(clk), .go(go), .hold_clks(hold_clks),
    .reset_pin_b(reset_pin_b));
  // short watchdog limit keeps the run brief
  hrs_reset_sequencer #(.WD_LIMIT(16'h0004)) dut_u (
    .clk(clk), .rst_b(rst_b), .reset_pin_b(reset_pin_b),
    .external_fetch_select(external_fetch_select), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ale_o(ale_o), .ale_oe(ale_oe),
    .program_fetch_strobe_b_o(program_fetch_strobe_b_o),
    .program_fetch_strobe_oe(program_fetch_strobe_oe), .fetch_address(fetch_address),
    .fetch_address_oe(fetch_address_oe), .port_o(port_o), .port_oe(port_oe),
    .core_reset(core_reset), .core_halt(core_halt));

  // ****************************************
  // tasks
  // ****************************************
  function [31:0] def_val(input [7:0] ad);
    case (ad)
      `HRS_OFS_STACK: def_val = {24'h0, `HRS_RST_STACK};
      `HRS_OFS_DATA_POINTER_PAIR: def_val = {16'h0, `HRS_RST_DATA_POINTER_PAIR};
      `HRS_OFS_WDOG: def_val = {16'h0, `HRS_RST_WDOG};
      `HRS_OFS_CONTROL: def_val = {24'h0, `HRS_RST_CTRL};
      `HRS_OFS_PORT_LO: def_val = {4{`HRS_RST_PORT}};
      `HRS_OFS_PORT_HI: def_val = {16'h0, {2{`HRS_RST_PORT}}};
      default: def_val = 32'h0;
    endcase
  endfunction

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // request held until the edge that samples waitrequest low
  task bus(input w, input [7:0] ad, input [31:0] d, output [31:0] q);
    integer c;
    begin
      avs_address <= ad;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      c = 0;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0 && c < 50) begin
        @(posedge clk);
        c = c + 1;
      end
      chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
    end
  endtask

  task check_defaults;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        bus(1'b0, OFS[8*i +: 8], 32'h0, rd);
        chk("register", def_val(OFS[8*i +: 8]), rd);
      end
    end
  endtask

  task pulse(input [7:0] h);
    begin
      go <= 1'b1;
      hold_clks <= h;
      @(posedge clk);
      go <= 1'b0;
    end
  endtask

  task wait_idle;
    begin
      t = 0;
      do begin
        @(negedge clk);
        t = t + 1;
      end while (core_reset !== 1'b0 && t < 300);
      chk("core_reset", 32'h0, {31'h0, core_reset});
      @(posedge clk);
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  // ****************************************
  // clock, watchdog and tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // the tests need under 1000 cycles
  initial begin
    #200000;
    err_total = err_total + 1;
    stop_test;
  end

  initial begin
    err_total = 0;
    total_checks = 0;
    rst_b = 1'b0;
    go = 1'b0;
    hold_clks = 8'h18;
    external_fetch_select = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    void'($urandom(76348));
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    wait_idle;
    check_defaults;
    bus(1'b1, 8'h30, $urandom, rd);
    bus(1'b0, 8'h30, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    $display("test defaults done");
    pulse(8'h0C);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (core_reset !== 1'b0) n = n + 1;
    end
    chk("glitch", 32'h0, n);
    @(posedge clk);
    $display("test glitch done");
    for (k = 0; k < 3; k = k + 1) begin
      ram_v = $urandom & 32'hFF;
      ra = `HRS_OFS_RAM + {k[3:0], 2'b00};
      external_fetch_select <= ($urandom % 2) == 1;
      bus(1'b1, ra, ram_v, rd);
      bus(1'b1, `HRS_OFS_STACK, $urandom & 32'hFF, rd);
      bus(1'b1, `HRS_OFS_DATA_POINTER_PAIR, $urandom & 32'hFFFF, rd);
      bus(1'b1, `HRS_OFS_PORT_LO, $urandom, rd);
      bus(1'b1, `HRS_OFS_CONTROL, {31'h0, k[0]}, rd);
      chk("halt", {31'h0, k[0]}, {31'h0, core_halt});
      pulse((k == 0) ? 8'h18 : 8'h18 + ($urandom % 40));
      t = 0;
      do begin
        @(negedge clk);
        t = t + 1;
      end while (reset_pin_b !== 1'b1 && t < 200);
      chk("core_reset", 32'h1, {31'h0, core_reset});
      chk("strobe oe", 32'h0, {30'h0, ale_oe, program_fetch_strobe_oe});
      a = 1'b0;
      n = 0;
      do begin
        a = (ale_o === 1'b1);
        @(negedge clk);
        n = n + 1;
      end while (!(a && ale_o === 1'b0) && n < 60);
      chk("release to strobe", 32'h1, {31'h0, n >= 12 && n < 24});
      chk("fetch strobe", {30'h0, !external_fetch_select, external_fetch_select},
          {30'h0, program_fetch_strobe_b_o, fetch_address_oe});
      wait_idle;
      chk("halt", 32'h0, {31'h0, core_halt});
      check_defaults;
      bus(1'b0, ra, 32'h0, rd);
      chk("ram", ram_v, rd);
      $display("test pin reset %0d done", k);
    end
    bus(1'b1, `HRS_OFS_CONTROL, 32'h2, rd);
    t = 0;
    do begin
      @(negedge clk);
      t = t + 1;
    end while (core_reset !== 1'b1 && t < 300);
    chk("watchdog reset", 32'h1, {31'h0, core_reset});
    wait_idle;
    bus(1'b0, `HRS_OFS_STATUS, 32'h0, rd);
    chk("watchdog cause", 32'h1, {31'h0, rd[`HRS_ST_CAUSE_WDT]});
    check_defaults;
    $display("test watchdog done");
    stop_test;
  end
endmodule
